// >>> opreg_file.sv
// Operational register bank of the 8-bit controller core
//
// Functional notes
// - Address 00h has no storage; it reaches the location chosen by select, except writes to select itself.
// - Jump loads low 10 PC bits; call also pushes PC plus one.
// - Return restores whole PC from stack top; page bits unchanged.
// - Jump, call and PC writes copy page bits into PC top bits.
// - Time-out and power-down flags set and cleared by their events.
// - Flag pair reads 00, 01, 10, 11 after the listed wake events.
// - Select bits 7:6 choose one of four banks for banked area.
// - Select bits 5:0 give indirect address; otherwise plain storage.
// - Port 5 bit 0 selects the control register page.
// - Port 5 data in bits 7:4; ports 6-8 eight bits, external direction.
// - LCD bias bit and duty bits select bias and duty.
// - LCD disabled drives all common and segment data to ground.
// - Frame bits pick the frame divisor per duty.
// - 5-bit LCD address picks segment; data nibble holds commons 3:0.
// - Run bits 3:0 start or stop the four timers.
// - Clock select bits give the PLL multiplier.
// - Sleep enters idle or sleep by idle bit; software adds no-op.
// - CPU source bit 0 clear runs from sub clock and halts main oscillator.
// - Carrier bit modulates low portions; otherwise plain PWM, counter 2 free.
// - Long-low bit ignores the high width timer.
// - IR control bits 3:0 switch port 5 pins 7:4 functions.
// - Interrupt status bits set on their eight events.
// - Request raised only when a flag and its enable are both set.
`timescale 1ns/10ps
module opreg_file import opreg_pkg::*; (
	input wire logic ref_clk, // 20 MHz clock
	input wire logic rst_n, // Async reset, power-up or reset pin
	input wire logic [5:0] reg_addr, // Register address from core
	input wire logic reg_wr, // Register write strobe
	input wire logic [7:0] reg_wdata, // Register write data
	output logic [7:0] reg_rdata_ff, // Read data, one cycle later
	input wire cpu_ins_s ins, // Instruction events from core
	output logic [11:0] pc_ff, // Program counter
	input wire logic wdt_timeout, // Watchdog expiry pulse
	input wire logic rst_pin_wake, // Reset pin wake from sleep pulse
	input wire logic wake_event, // Pin change wake pulse
	output pwr_e pwr_mode_ff, // Run, idle or sleep
	output logic ctl_page_ff, // Control register page select
	input wire logic [7:4] p5_in, // Port 5 pin levels
	input wire logic [7:4] p5_dir, // Port 5 direction, 1 is input
	output logic [7:4] p5_out_ff, // Port 5 pin drive
	output logic [7:4] p5_oe_ff, // Port 5 output enable
	input wire logic [2:0][7:0] px_in, // Ports 6,7,8 pin levels
	input wire logic [2:0][7:0] px_dir, // Ports 6,7,8 direction
	output logic [2:0][7:0] px_out_ff, // Ports 6,7,8 pin drive
	output logic [2:0][7:0] px_oe_ff, // Ports 6,7,8 output enable
	input wire logic ext_irq0_pin_fall_sel, // Interrupt 0 edge, 1 is falling
	input wire logic tcc_tick, // Counter advance pulse
	input wire logic [3:0] tmr_uflow, // Low, high, cnt2, cnt1 underflow
	input wire logic [7:0] irq_mask, // Interrupt enables
	output logic irq_req_ff, // Interrupt request level
	output logic [3:0] tmr_run_ff, // Timer run enables
	output logic cnt2_free_ff, // Counter 2 as plain reload timer
	input wire logic ir_high_phase, // PWM generator in high section
	input wire logic ir_carrier, // Counter 2 carrier level
	output logic [3:0] pin_fn_ff, // IR, counter, ext_irq1_pin, ext_irq0_pin pin use
	output lcd_cfg_s lcd_cfg_ff, // LCD drive settings
	input wire logic [4:0] lcd_scan_seg, // Segment being scanned
	output logic [3:0] lcd_scan_ff, // Common data for that segment
	output clk_cfg_s clk_cfg_ff // Clock settings
);
	// ==========================================
	// Storage
	logic [7:0] stat_ff, rsel_ff, tcc_ff, p5_ff, lcdc_ff, ladr_ff;
	logic [7:0] clkc_ff, irc_ff, iflg_ff;
	logic [7:0] gp_lo [16];
	logic [7:0] gp_bank [4][32];
	logic [3:0] lcd_mem [32];
	logic [11:0] stk [STK_DEPTH];
	logic [2:0] sp_ff;
	logic [7:0] p6_prev_ff, p8_prev_ff;
	logic [5:4] int_prev_ff;
	logic [5:0] eff;
	logic [7:0] ev, nxt_rdata;
	logic [1:0] ps;
	logic ir_wave;

	assign eff = (reg_addr == A_IND) ? rsel_ff[5:0] : reg_addr;
	assign ps = stat_ff[ST_PS+1:ST_PS];

	function automatic logic hit(input logic [5:0] a);
		return reg_wr && (eff == a);
	endfunction

	// ==========================================
	// Program counter and stack
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_ff <= RST_PC;
			sp_ff <= 3'h0;
		end else if (ins.ret) begin
			pc_ff <= stk[sp_ff - 3'h1];
			sp_ff <= sp_ff - 3'h1;
		end else if (ins.jump || ins.call) begin
			pc_ff <= {ps, ins.target};
			if (ins.call) begin
				sp_ff <= sp_ff + 3'h1;
			end
		end else if (hit(A_PCL)) begin
			pc_ff <= {ps, pc_ff[9:8], reg_wdata};
		end else if (ins.step) begin
			pc_ff <= pc_ff + 12'h001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (ins.call && !ins.ret) begin
			stk[sp_ff] <= pc_ff + 12'h001;
		end
	end

	// ==========================================
	// Status, time-out and power-down flags
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_ff <= RST_STAT;
		end else begin
			if (hit(A_STAT)) begin
				stat_ff <= (stat_ff & ~M_STAT) | (reg_wdata & M_STAT);
			end else if (ins.flag_we) begin
				stat_ff[2:0] <= ins.flags;
			end
			if (ins.sleep) begin
				stat_ff[ST_T] <= 1'b1;
				stat_ff[ST_P] <= 1'b0;
			end else if (ins.watchdog_clear_instruction) begin
				stat_ff[ST_T] <= 1'b1;
				stat_ff[ST_P] <= 1'b1;
			end else if (rst_pin_wake) begin
				stat_ff[ST_T] <= 1'b1;
				stat_ff[ST_P] <= 1'b0;
			end else if (wdt_timeout) begin
				stat_ff[ST_T] <= 1'b0;
				stat_ff[ST_P] <= (pwr_mode_ff == PM_RUN);
			end
		end
	end

	// ==========================================
	// Power mode
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_mode_ff <= PM_RUN;
		end else begin
			case (pwr_mode_ff)
				PM_RUN: begin
					if (ins.sleep) begin
						pwr_mode_ff <= clkc_ff[CK_IDLE] ? PM_IDLE :
							PM_SLEEP;
					end
				end
				PM_IDLE, PM_SLEEP: begin
					if (wdt_timeout || rst_pin_wake || wake_event) begin
						pwr_mode_ff <= PM_RUN;
					end
				end
				default: pwr_mode_ff <= PM_RUN;
			endcase
		end
	end

	// ==========================================
	// Plain control registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsel_ff <= RST_ZERO;
			p5_ff <= RST_ZERO;
			px_out_ff <= '0;
			lcdc_ff <= RST_ZERO;
			ladr_ff <= RST_ZERO;
			tmr_run_ff <= 4'h0;
			clkc_ff <= RST_ZERO;
			irc_ff <= RST_ZERO;
		end else begin
			if (reg_wr && reg_addr == A_RSEL) begin
				rsel_ff <= reg_wdata;
			end
			if (hit(A_P5)) begin
				p5_ff <= reg_wdata & M_P5;
			end
			if (hit(A_P6)) begin
				px_out_ff[0] <= reg_wdata;
			end
			if (hit(A_P7)) begin
				px_out_ff[1] <= reg_wdata;
			end
			if (hit(A_P8)) begin
				px_out_ff[2] <= reg_wdata;
			end
			if (hit(A_LCDC)) begin
				lcdc_ff <= reg_wdata & M_LCDC;
			end
			if (hit(A_LADR)) begin
				ladr_ff <= reg_wdata & M_LADR;
			end
			if (hit(A_TRUN)) begin
				tmr_run_ff <= reg_wdata[3:0];
			end
			if (hit(A_CLKC)) begin
				clkc_ff <= reg_wdata & M_CLKC;
			end
			if (hit(A_IRC)) begin
				irc_ff <= reg_wdata & M_IRC;
			end
		end
	end

	// General purpose storage; banked area follows select bits 7:6
	always_ff @(posedge ref_clk) begin
		if (reg_wr && eff >= A_BANKED) begin
			gp_bank[rsel_ff[7:6]][eff[4:0]] <= reg_wdata;
		end else if (reg_wr && eff >= A_GP_LO) begin
			gp_lo[eff[3:0]] <= reg_wdata;
		end
		if (hit(A_LDAT)) begin
			lcd_mem[ladr_ff[4:0]] <= reg_wdata[3:0];
		end
	end

	// ==========================================
	// Counter and interrupt flags
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tcc_ff <= RST_ZERO;
		end else if (hit(A_TCC)) begin
			tcc_ff <= reg_wdata;
		end else if (tcc_tick) begin
			tcc_ff <= tcc_ff + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			p6_prev_ff <= RST_ZERO;
			p8_prev_ff <= RST_ZERO;
			int_prev_ff <= 2'h0;
		end else begin
			p6_prev_ff <= px_in[0];
			p8_prev_ff <= px_in[2];
			int_prev_ff <= p5_in[5:4];
		end
	end

	always_comb begin
		ev[7] = |(px_in[0] ^ p6_prev_ff) | |(px_in[2] ^ p8_prev_ff);
		ev[6:3] = tmr_uflow;
		ev[2] = irc_ff[1] && int_prev_ff[5] && !p5_in[5];
		ev[1] = irc_ff[0] && (ext_irq0_pin_fall_sel ?
			(int_prev_ff[4] && !p5_in[4]) : (!int_prev_ff[4] && p5_in[4]));
		ev[0] = tcc_tick && !hit(A_TCC) && (tcc_ff == 8'hFF);
	end

	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			iflg_ff <= RST_ZERO;
		end else if (hit(A_IFLG)) begin
			iflg_ff <= (iflg_ff & reg_wdata) | ev;
		end else begin
			iflg_ff <= iflg_ff | ev;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req_ff <= 1'b0;
		end else begin
			irq_req_ff <= |(iflg_ff & irq_mask);
		end
	end

	// ==========================================
	// Pins and infrared output
	assign ir_wave = (irc_ff[IR_LGP] ? 1'b0 : ir_high_phase) |
		(irc_ff[IR_HF] & ir_carrier);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			p5_out_ff <= 4'h0;
			p5_oe_ff <= 4'h0;
			px_oe_ff <= '0;
			pin_fn_ff <= 4'h0;
			cnt2_free_ff <= 1'b1;
			ctl_page_ff <= 1'b0;
		end else begin
			p5_out_ff <= p5_ff[7:4];
			if (irc_ff[3] && irc_ff[IR_IRE]) begin
				p5_out_ff[7] <= ir_wave;
			end
			p5_oe_ff <= ~p5_dir;
			px_oe_ff <= ~px_dir;
			pin_fn_ff <= irc_ff[3:0];
			cnt2_free_ff <= !(irc_ff[IR_IRE] && irc_ff[IR_HF]);
			ctl_page_ff <= p5_ff[P5_PAGE];
		end
	end

	// ==========================================
	// LCD and clock settings
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lcd_cfg_ff <= '0;
			lcd_scan_ff <= 4'h0;
			clk_cfg_ff <= '0;
		end else begin
			lcd_cfg_ff.enable <= lcdc_ff[LC_EN];
			lcd_cfg_ff.bias_third <= lcdc_ff[LC_BS];
			lcd_cfg_ff.duty <= lcdc_ff[LC_DS+1:LC_DS];
			lcd_cfg_ff.wave_b <= lcdc_ff[LC_TYPE];
			lcd_cfg_ff.frame <= lcdc_ff[1:0];
			lcd_cfg_ff.frame_div <= frame_div(lcdc_ff[LC_DS+1:LC_DS],
				lcdc_ff[1:0]);
			lcd_scan_ff <= lcdc_ff[LC_EN] ?
				lcd_mem[lcd_scan_seg] : 4'h0;
			clk_cfg_ff.cpu_main <= clkc_ff[CK_CPU];
			clk_cfg_ff.main_halt <= !clkc_ff[CK_CPU];
			clk_cfg_ff.boost <= clkc_ff[CK_BF+1:CK_BF];
			clk_cfg_ff.pll_shift <= 2'h0;
			if (clkc_ff[CK_MUL+2]) begin
				clk_cfg_ff.pll_mul <= 8'hF4;
			end else if (clkc_ff[CK_MUL+1:CK_MUL] == 2'h0) begin
				clk_cfg_ff.pll_mul <= 8'h82;
			end else begin
				clk_cfg_ff.pll_mul <= 8'h41;
				clk_cfg_ff.pll_shift <= clkc_ff[CK_MUL+1:CK_MUL] - 2'h1;
			end
		end
	end

	// ==========================================
	// Read path; input bits show the pin, output bits the latch
	always_comb begin
		nxt_rdata = RST_ZERO;
		case (eff)
			A_IND: nxt_rdata = RST_ZERO;
			A_TCC: nxt_rdata = tcc_ff;
			A_PCL: nxt_rdata = pc_ff[7:0];
			A_STAT: nxt_rdata = stat_ff;
			A_RSEL: nxt_rdata = rsel_ff;
			A_P5: nxt_rdata = {(p5_in & p5_dir) | (p5_ff[7:4] & ~p5_dir),
				p5_ff[3:0]};
			A_P6: nxt_rdata = (px_in[0] & px_dir[0]) |
				(px_out_ff[0] & ~px_dir[0]);
			A_P7: nxt_rdata = (px_in[1] & px_dir[1]) |
				(px_out_ff[1] & ~px_dir[1]);
			A_P8: nxt_rdata = (px_in[2] & px_dir[2]) |
				(px_out_ff[2] & ~px_dir[2]);
			A_LCDC: nxt_rdata = lcdc_ff;
			A_LADR: nxt_rdata = ladr_ff;
			A_LDAT: nxt_rdata = {4'h0, lcd_mem[ladr_ff[4:0]]};
			A_TRUN: nxt_rdata = {4'h0, tmr_run_ff};
			A_CLKC: nxt_rdata = clkc_ff;
			A_IRC: nxt_rdata = irc_ff;
			A_IFLG: nxt_rdata = iflg_ff;
			default: begin
				if (eff >= A_BANKED) begin
					nxt_rdata = gp_bank[rsel_ff[7:6]][eff[4:0]];
				end else begin
					nxt_rdata = gp_lo[eff[3:0]];
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_ff <= RST_ZERO;
		end else begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// ==========================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_sleep_alone;
		ins.sleep && !ins.watchdog_clear_instruction && !wdt_timeout && !rst_pin_wake;
	endsequence

	property p_ind;
		reg_wr && reg_addr == A_IND && rsel_ff[5:0] == A_TRUN
			|=> tmr_run_ff == $past(reg_wdata[3:0]);
	endproperty
	a_ind: assert property (p_ind) else $error("indirect write lost");

	property p_jump;
		ins.jump && !ins.ret |=> pc_ff == {$past(ps), $past(ins.target)};
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");

	property p_call_ret;
		ins.call && !ins.ret ##1 ins.ret && !ins.call
			|=> pc_ff == $past(pc_ff, 2) + 12'h001;
	endproperty
	a_call_ret: assert property (p_call_ret) else $error("return wrong");

	property p_sleep_flags;
		s_sleep_alone |=> stat_ff[ST_T] && !stat_ff[ST_P];
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("T/P bad");

	property p_sleep_mode;
		s_sleep_alone and (pwr_mode_ff == PM_RUN) |=> pwr_mode_ff ==
			($past(clkc_ff[CK_IDLE]) ? PM_IDLE : PM_SLEEP);
	endproperty
	a_sleep_mode: assert property (p_sleep_mode) else $error("mode bad");

	property p_lcd_off;
		!lcdc_ff[LC_EN] |=> lcd_scan_ff == 4'h0;
	endproperty
	a_lcd_off: assert property (p_lcd_off) else $error("LCD not ground");

	property p_flag_keep;
		|ev |=> (iflg_ff & $past(ev)) == $past(ev);
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("event lost");

	property p_irq;
		##1 irq_req_ff == |($past(iflg_ff) & $past(irq_mask));
	endproperty
	a_irq: assert property (p_irq) else $error("request mismatch");
endmodule

// >>> opreg_pkg.sv
// Constants and carrier types for the operational register bank
package opreg_pkg;
	// ==========================================
	// Register offsets
	localparam logic [5:0] A_IND = 6'h00;
	localparam logic [5:0] A_TCC = 6'h01;
	localparam logic [5:0] A_PCL = 6'h02;
	localparam logic [5:0] A_STAT = 6'h03;
	localparam logic [5:0] A_RSEL = 6'h04;
	localparam logic [5:0] A_P5 = 6'h05;
	localparam logic [5:0] A_P6 = 6'h06;
	localparam logic [5:0] A_P7 = 6'h07;
	localparam logic [5:0] A_P8 = 6'h08;
	localparam logic [5:0] A_LCDC = 6'h09;
	localparam logic [5:0] A_LADR = 6'h0A;
	localparam logic [5:0] A_LDAT = 6'h0B;
	localparam logic [5:0] A_TRUN = 6'h0C;
	localparam logic [5:0] A_CLKC = 6'h0D;
	localparam logic [5:0] A_IRC = 6'h0E;
	localparam logic [5:0] A_IFLG = 6'h0F;
	localparam logic [5:0] A_GP_LO = 6'h10;
	localparam logic [5:0] A_BANKED = 6'h20;
	// ==========================================
	// Field positions
	localparam int ST_PS = 5;
	localparam int ST_T = 4;
	localparam int ST_P = 3;
	localparam int LC_BS = 7;
	localparam int LC_DS = 5;
	localparam int LC_EN = 4;
	localparam int LC_TYPE = 2;
	localparam int CK_MUL = 4;
	localparam int CK_IDLE = 3;
	localparam int CK_BF = 1;
	localparam int CK_CPU = 0;
	localparam int IR_IRE = 7;
	localparam int IR_HF = 6;
	localparam int IR_LGP = 5;
	localparam int P5_PAGE = 0;
	// ==========================================
	// Reset values and writable masks
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_STAT = 8'h18;
	localparam logic [11:0] RST_PC = 12'h000;
	localparam logic [7:0] M_STAT = 8'h67;
	localparam logic [7:0] M_P5 = 8'hF1;
	localparam logic [7:0] M_LADR = 8'h1F;
	localparam logic [7:0] M_LDAT = 8'h0F;
	localparam logic [7:0] M_TRUN = 8'h0F;
	localparam logic [7:0] M_CLKC = 8'h7F;
	localparam logic [7:0] M_IRC = 8'hEF;
	localparam logic [7:0] M_LCDC = 8'hF7;
	localparam int STK_DEPTH = 8;

	typedef enum logic [1:0] {
		PM_RUN = 2'b00,
		PM_IDLE = 2'b01,
		PM_SLEEP = 2'b11
	} pwr_e;

	typedef struct packed {
		logic jump;
		logic call;
		logic ret;
		logic step;
		logic sleep;
		logic watchdog_clear_instruction;
		logic flag_we;
		logic [2:0] flags;
		logic [9:0] target;
	} cpu_ins_s;

	typedef struct packed {
		logic enable;
		logic bias_third;
		logic [1:0] duty;
		logic wave_b;
		logic [1:0] frame;
		logic [9:0] frame_div;
	} lcd_cfg_s;

	typedef struct packed {
		logic cpu_main;
		logic main_halt;
		logic [7:0] pll_mul;
		logic [1:0] pll_shift;
		logic [1:0] boost;
	} clk_cfg_s;

	// Frame period divisor, already multiplied by the duty count
	function automatic logic [9:0] frame_div(input logic [1:0] ds,
		input logic [1:0] fr);
		logic [8:0] b;
		logic [2:0] n;
		b = 9'h000;
		n = 3'h4;
		if (ds[1]) begin
			case (fr)
				2'h0: b = 9'h080;
				2'h1: b = 9'h08C;
				2'h2: b = 9'h098;
				default: b = 9'h074;
			endcase
		end else if (ds[0]) begin
			n = 3'h3;
			case (fr)
				2'h0: b = 9'h0AC;
				2'h1: b = 9'h0BC;
				2'h2: b = 9'h0CC;
				default: b = 9'h09C;
			endcase
		end else begin
			n = 3'h2;
			case (fr)
				2'h0: b = 9'h100;
				2'h1: b = 9'h118;
				2'h2: b = 9'h130;
				default: b = 9'h0E8;
			endcase
		end
		return 10'({1'b0, b} * {7'h00, n});
	endfunction
endpackage

// >>> cpu_model.sv
// Core-side model that issues register accesses and instruction events
`timescale 1ns/10ps
module cpu_model import opreg_pkg::*; (
	input wire logic ref_clk, // Core clock
	output logic [5:0] reg_addr, // Register address
	output logic reg_wr, // Write strobe
	output logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata_ff, // Read data
	output cpu_ins_s ins // Instruction events
);
	initial begin
		reg_addr = A_TCC;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		ins = '0;
	end
	// ==========================================
	// Access tasks
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Data is registered, so it is taken one edge after the address
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		@(posedge ref_clk);
		#1 d = reg_rdata_ff;
	endtask
	task automatic op(input cpu_ins_s v);
		@(posedge ref_clk);
		ins <= v;
		@(posedge ref_clk);
		ins <= '0;
		#1;
	endtask
	// Clearing flags only ever writes zeros
	task automatic clr_flags();
		wr(A_IFLG, 8'h00);
	endtask
	// A no-op always follows the sleep instruction
	task automatic sleep_op();
		cpu_ins_s v;
		v = '0;
		v.sleep = 1'b1;
		op(v);
		v = '0;
		v.step = 1'b1;
		op(v);
	endtask
endmodule

// >>> mcu_operational_register_file_bench.sv
// Self-checking bench of the operational register bank
`timescale 1ns/10ps
module mcu_operational_register_file_bench import opreg_pkg::*;;
	logic ref_clk, rst_n, irq_req_ff, ctl_page_ff, cnt2_free_ff, tcc_tick;
	logic ir_high_phase, ir_carrier;
	logic [5:0] reg_addr;
	logic reg_wr;
	logic [7:0] reg_wdata, reg_rdata_ff, irq_mask, d;
	cpu_ins_s ins, v;
	logic [11:0] pc_ff;
	logic [2:0] pev;
	pwr_e pwr_mode_ff;
	logic [7:4] p5_in, p5_dir, p5_out_ff, p5_oe_ff;
	logic [2:0][7:0] px_in, px_dir, px_out_ff, px_oe_ff;
	logic [3:0] tmr_uflow, tmr_run_ff, pin_fn_ff, lcd_scan_ff;
	lcd_cfg_s lcd_cfg_ff;
	clk_cfg_s clk_cfg_ff;
	logic [4:0] lcd_scan_seg;
	int n_fail, cmp_count;
	logic [5:0] ra [8] = '{A_RSEL, A_LADR, A_LDAT, A_TRUN, A_CLKC, A_IRC,
		A_LCDC, A_STAT};
	logic [7:0] rm [8] = '{8'hFF, 8'h1F, 8'h0F, 8'h0F, 8'h7F, 8'hEF, 8'hF7,
		8'h67};
	logic [9:0] dv [3][4] = '{'{10'h200, 10'h230, 10'h260, 10'h1D0},
		'{10'h204, 10'h234, 10'h264, 10'h1D4},
		'{10'h200, 10'h230, 10'h260, 10'h1D0}};

	opreg_file opreg_file_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff), .ins(ins), .pc_ff(pc_ff),
		.wdt_timeout(pev[0]), .rst_pin_wake(pev[1]), .wake_event(pev[2]),
		.pwr_mode_ff(pwr_mode_ff), .ctl_page_ff(ctl_page_ff),
		.p5_in(p5_in), .p5_dir(p5_dir), .p5_out_ff(p5_out_ff),
		.p5_oe_ff(p5_oe_ff), .px_in(px_in), .px_dir(px_dir),
		.px_out_ff(px_out_ff), .px_oe_ff(px_oe_ff), .ext_irq0_pin_fall_sel(1'b0),
		.tcc_tick(tcc_tick), .tmr_uflow(tmr_uflow), .irq_mask(irq_mask),
		.irq_req_ff(irq_req_ff), .tmr_run_ff(tmr_run_ff),
		.cnt2_free_ff(cnt2_free_ff), .ir_high_phase(ir_high_phase),
		.ir_carrier(ir_carrier), .pin_fn_ff(pin_fn_ff),
		.lcd_cfg_ff(lcd_cfg_ff), .lcd_scan_seg(lcd_scan_seg),
		.lcd_scan_ff(lcd_scan_ff), .clk_cfg_ff(clk_cfg_ff));
	cpu_model cpu_model_inst (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff), .ins(ins));

	always #25 ref_clk = ~ref_clk;

	// ==========================================
	// Helpers
	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string m);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t %s got %0h exp %0h", $time, m, g, e);
		end
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] e,
		input string m);
		logic [7:0] r;
		cpu_model_inst.rd(a, r);
		chk({8'h00, r}, {8'h00, e}, m);
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic jmp(input logic [2:0] k, input logic [9:0] t);
		v = '0;
		{v.ret, v.call, v.jump} = k;
		v.target = t;
		cpu_model_inst.op(v);
	endtask
	task automatic pulse(input logic [2:0] p);
		@(posedge ref_clk);
		pev <= p;
		@(posedge ref_clk);
		pev <= 3'h0;
		#1;
	endtask
	task automatic tp(input logic [1:0] e);
		cpu_model_inst.rd(A_STAT, d);
		chk({14'h0, d[4:3]}, {14'h0, e}, "time-out/power-down");
	endtask
	task automatic ir(input logic [7:0] c, input logic h, input logic k,
		input logic [1:0] e);
		@(posedge ref_clk);
		ir_high_phase <= h;
		ir_carrier <= k;
		cpu_model_inst.wr(A_IRC, c);
		tk(2);
		chk({14'h0, cnt2_free_ff, p5_out_ff[7]}, {14'h0, e}, "ir");
	endtask
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		final_report();
	end

	// ==========================================
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		pev = 3'h0;
		p5_in = 4'hF;
		p5_dir = 4'h7;
		px_in = '0;
		px_dir = {8'hFF, 8'hFF, 8'h0F};
		tcc_tick = 1'b0;
		tmr_uflow = 4'h0;
		irq_mask = 8'h00;
		ir_high_phase = 1'b0;
		ir_carrier = 1'b0;
		lcd_scan_seg = 5'h00;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		chk({4'h0, pc_ff}, 16'h0000, "pc reset");
		tp(2'b11);
		cpu_model_inst.wr(A_STAT, 8'h20);
		jmp(3'h1, 10'h010);
		chk({4'h0, pc_ff}, 16'h0410, "jump");
		jmp(3'h2, 10'h123);
		chk({4'h0, pc_ff}, 16'h0523, "call");
		cpu_model_inst.wr(A_STAT, 8'h40);
		jmp(3'h1, 10'h3FF);
		chk({4'h0, pc_ff}, 16'h0BFF, "jump top");
		jmp(3'h4, 10'h000);
		chk({4'h0, pc_ff}, 16'h0411, "return");
		cpu_model_inst.wr(A_PCL, 8'h44);
		tk(1);
		chk({6'h0, pc_ff[11:10], pc_ff[7:0]}, 16'h0244, "pc wr");
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 8; i++) begin
				cpu_model_inst.wr(ra[i], k ? 8'h00 : 8'hFF);
				rchk(ra[i], (k ? 8'h00 : rm[i]) |
					(ra[i] == A_STAT ? 8'h18 : 8'h00), "rw");
			end
		end
		cpu_model_inst.wr(A_TRUN, 8'h09);
		tk(1);
		chk({12'h0, tmr_run_ff}, 16'h0009, "run");
		cpu_model_inst.wr(A_RSEL, 8'h10);
		cpu_model_inst.wr(A_IND, 8'h5A);
		rchk(A_GP_LO, 8'h5A, "indirect");
		cpu_model_inst.wr(A_RSEL, 8'h40);
		cpu_model_inst.wr(A_BANKED, 8'h22);
		cpu_model_inst.wr(A_RSEL, 8'h00);
		cpu_model_inst.wr(A_BANKED, 8'h11);
		rchk(A_BANKED, 8'h11, "bank 0");
		cpu_model_inst.wr(A_RSEL, 8'h40);
		rchk(A_BANKED, 8'h22, "bank 1");
		cpu_model_inst.wr(A_P5, 8'hA1);
		cpu_model_inst.wr(A_P6, 8'hC3);
		tk(2);
		chk({ctl_page_ff, 3'h0, p5_out_ff, px_out_ff[0]}, 16'h8AC3,
			"ports");
		chk({p5_oe_ff, 4'h0, px_oe_ff[0]}, 16'h80F0, "dir");
		for (int i = 0; i < 16; i++) begin
			cpu_model_inst.wr(A_LCDC, {i[0], i[3:2], 3'b100, i[1:0]});
			tk(2);
			chk({lcd_cfg_ff.bias_third, lcd_cfg_ff.duty, 3'h0,
				lcd_cfg_ff.frame_div}, {i[0], i[3:2], 3'h0,
				dv[i[3] ? 2 : i[2]][i[1:0]]}, "lcd");
		end
		cpu_model_inst.wr(A_LADR, 8'h05);
		cpu_model_inst.wr(A_LDAT, 8'h09);
		@(posedge ref_clk);
		lcd_scan_seg <= 5'h05;
		tk(2);
		chk({12'h0, lcd_scan_ff}, 16'h0009, "lcd ram");
		cpu_model_inst.wr(A_LCDC, 8'h00);
		tk(2);
		chk({12'h0, lcd_scan_ff}, 16'h0000, "lcd off");
		for (int c = 0; c < 8; c++) begin
			cpu_model_inst.wr(A_CLKC, {1'b0, c[2:0], 4'h1});
			tk(2);
			chk({clk_cfg_ff.pll_mul, 2'h0, clk_cfg_ff.pll_shift,
				clk_cfg_ff.cpu_main, clk_cfg_ff.main_halt, 2'h0},
				{c > 3 ? 8'hF4 : (c == 0 ? 8'h82 : 8'h41), 2'h0,
				(c > 3 || c == 0) ? 2'h0 : 2'(c - 1), 4'h8},
				"pll");
		end
		cpu_model_inst.wr(A_CLKC, 8'h00);
		tk(2);
		chk({14'h0, clk_cfg_ff.cpu_main, clk_cfg_ff.main_halt}, 16'h0001,
			"sub clock");
		ir(8'hC8, 1'b0, 1'b1, 2'b01);
		ir(8'h88, 1'b1, 1'b1, 2'b11);
		ir(8'hE8, 1'b1, 1'b0, 2'b00);
		chk({12'h0, pin_fn_ff}, 16'h0008, "pin fn");
		cpu_model_inst.wr(A_CLKC, 8'h09);
		cpu_model_inst.sleep_op();
		chk({14'h0, pwr_mode_ff}, {14'h0, PM_IDLE}, "idle");
		tp(2'b10);
		pulse(3'b100);
		chk({14'h0, pwr_mode_ff}, {14'h0, PM_RUN}, "wake");
		pulse(3'b001);
		tp(2'b01);
		v = '0;
		v.watchdog_clear_instruction = 1'b1;
		cpu_model_inst.op(v);
		tp(2'b11);
		cpu_model_inst.wr(A_CLKC, 8'h01);
		cpu_model_inst.sleep_op();
		chk({14'h0, pwr_mode_ff}, {14'h0, PM_SLEEP}, "sleep");
		pulse(3'b001);
		tp(2'b00);
		pulse(3'b010);
		tp(2'b10);
		cpu_model_inst.wr(A_IRC, 8'h03);
		cpu_model_inst.clr_flags();
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			tmr_uflow <= 4'(1 << i);
		end
		@(posedge ref_clk);
		tmr_uflow <= 4'h0;
		px_in[0] <= 8'h01;
		cpu_model_inst.wr(A_TCC, 8'hFF);
		@(posedge ref_clk);
		tcc_tick <= 1'b1;
		@(posedge ref_clk);
		tcc_tick <= 1'b0;
		p5_in <= 4'hC;
		@(posedge ref_clk);
		p5_in <= 4'hD;
		tk(2);
		rchk(A_IFLG, 8'hFF, "events");
		chk({15'h0, irq_req_ff}, 16'h0000, "masked");
		@(posedge ref_clk);
		irq_mask <= 8'h10;
		tk(2);
		chk({15'h0, irq_req_ff}, 16'h0001, "request");
		fork
			cpu_model_inst.clr_flags();
			begin
				@(posedge ref_clk);
				tmr_uflow <= 4'h2;
				@(posedge ref_clk);
				tmr_uflow <= 4'h0;
			end
		join
		rchk(A_IFLG, 8'h10, "set wins");
		cpu_model_inst.clr_flags();
		tk(2);
		chk({15'h0, irq_req_ff}, 16'h0000, "cleared");
		rchk(A_IFLG, 8'h00, "flags clear");
		final_report();
	end
endmodule
